// ### src/round_decide.sv
/*
 contents: per-element rounding increment decision.
 assumes: datapath supplies sign, kept lsb, guard and sticky bits.
*/
`include "vfp_status_map.svh"
`timescale 1ns/100ps
`default_nettype none

module round_decide (
   // clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       srst_in,
   // rounding inputs
   input  wire logic [1:0] mode_in,
   input  wire logic       sign_in,
   input  wire logic       lsb_in,
   input  wire logic       guard_in,
   input  wire logic       sticky_in,
   // decision
   output logic            round_up_out
);

   logic next_round_up;

   always_comb begin
      unique case (mode_in)
         `RM_NEAREST: next_round_up = guard_in & (sticky_in | lsb_in);
         `RM_ZERO:    next_round_up = 1'b0;
         `RM_PLUS:    next_round_up = ~sign_in & (guard_in | sticky_in);
         `RM_MINUS:   next_round_up = sign_in & (guard_in | sticky_in);
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         round_up_out <= 1'b0;
      end else begin
         round_up_out <= next_round_up;
      end
   end

   property p_rne_tie;
      @(posedge ref_clk_in) disable iff (srst_in)
      (mode_in == `RM_NEAREST && guard_in && !sticky_in && !lsb_in) |=> !round_up_out;
   endproperty
   a_rne_tie: assert property (p_rne_tie) else $error("tie not rounded to even");

   property p_rtz;
      @(posedge ref_clk_in) disable iff (srst_in)
      (mode_in == `RM_ZERO) |=> !round_up_out;
   endproperty
   a_rtz: assert property (p_rtz) else $error("toward zero incremented");

   property p_plus;
      @(posedge ref_clk_in) disable iff (srst_in)
      (mode_in == `RM_PLUS && (guard_in || sticky_in)) |=> (round_up_out == !$past(sign_in));
   endproperty
   a_plus: assert property (p_plus) else $error("plus infinity wrong");

   property p_minus;
      @(posedge ref_clk_in) disable iff (srst_in)
      (mode_in == `RM_MINUS && (guard_in || sticky_in)) |=> (round_up_out == $past(sign_in));
   endproperty
   a_minus: assert property (p_minus) else $error("minus infinity wrong");

endmodule : round_decide

`default_nettype wire

// ### src/vector_fp_flags_rounding.sv
/*
 contents: fp status logic of the vector unit: flags, cause, enable,
 mode and rounding selector, condition qualification, default result
 selection and per-element rounding decision.
 assumes: datapath pulses done_in once per completed instruction with
 its element reports; software writes the whole word at once.
*/
`include "vfp_status_map.svh"
`timescale 1ns/100ps
`default_nettype none

module vector_fp_flags_rounding #(
   parameter int NUM_ELEM = `NUM_ELEM
) (
   // clock and reset
   input  wire logic                                            ref_clk_in,
   input  wire logic                                            srst_in,
   // software access
   input  wire logic                                            csr_wr_in,
   input  wire vfp_status_pkg::csr_type                         csr_wdata_in,
   output vfp_status_pkg::csr_type                              csr_out,
   // datapath reports
   input  wire logic                                            done_in,
   input  wire logic [NUM_ELEM-1:0]                             elem_valid_in,
   input  wire vfp_status_pkg::elem_report_type [NUM_ELEM-1:0]  elem_in,
   // results back to datapath
   output logic                                                 trap_out,
   output logic [NUM_ELEM-1:0]                                  round_up_out,
   output vfp_status_pkg::default_kind_type [NUM_ELEM-1:0]      default_kind_out,
   output logic [NUM_ELEM-1:0]                                  default_sign_out
);

   logic [1:0] round_select;
   logic       nontrap_select;
   logic [4:0] enable;
   logic [5:0] cause;
   logic [4:0] flags;

   // element conditions, bit order per the map indices
   logic [5:0] cond      [NUM_ELEM];
   logic [4:0] flag_part [NUM_ELEM];
   logic [4:0] eff_en;
   logic [5:0] cause_acc;
   logic [4:0] flag_acc;
   logic       done_trap;
   logic       wr_trap;

   // non-trapping mode picks default results as if nothing were enabled
   assign eff_en = nontrap_select ? 5'h00 : enable;

   genvar g;
   generate
      for (g = 0; g < NUM_ELEM; g++) begin : g_elem
         logic [1:0] mode;
         logic       trapped;
         vfp_status_pkg::default_kind_type next_kind;

         assign cond[g][`C_UNIMPL]   = elem_in[g].unimpl;
         assign cond[g][`C_INVALID]  = elem_in[g].invalid;
         assign cond[g][`C_DIV_ZERO] = elem_in[g].div_zero;
         assign cond[g][`C_OVERFLOW] = elem_in[g].overflow;
         // tiny exact result only counts when underflow is enabled
         assign cond[g][`C_UNDERFLOW] = elem_in[g].tiny
            & (enable[`C_UNDERFLOW] | elem_in[g].inexact);
         assign cond[g][`C_INEXACT] = elem_in[g].inexact
            | (elem_in[g].overflow & ~enable[`C_OVERFLOW]);

         // unimplemented is always enabled when trapping is possible
         assign trapped = ~nontrap_select
            & (cond[g][`C_UNIMPL] | (|(cond[g][4:0] & enable)));

         // unimplemented has no flag position
         assign flag_part[g] = (elem_valid_in[g] & ~trapped)
            ? cond[g][4:0] : 5'h00;

         // some operations carry their own fixed rounding
         assign mode = elem_in[g].fixed_rm_valid ? elem_in[g].fixed_rm : round_select;

         always_comb begin
            if (cond[g][`C_INVALID] && !eff_en[`C_INVALID]) begin
               next_kind = vfp_status_pkg::DEF_QNAN;
            end else if (cond[g][`C_DIV_ZERO] && !eff_en[`C_DIV_ZERO]) begin
               next_kind = vfp_status_pkg::DEF_INF;
            end else begin
               next_kind = vfp_status_pkg::DEF_ROUNDED;
            end
         end

         always_ff @(posedge ref_clk_in) begin
            if (srst_in) begin
               default_kind_out[g] <= vfp_status_pkg::DEF_ROUNDED;
               default_sign_out[g] <= 1'b0;
            end else begin
               default_kind_out[g] <= next_kind;
               default_sign_out[g] <= elem_in[g].sign;
            end
         end

         round_decide u_round (
            .ref_clk_in   (ref_clk_in),
            .srst_in      (srst_in),
            .mode_in      (mode),
            .sign_in      (elem_in[g].sign),
            .lsb_in       (elem_in[g].lsb),
            .guard_in     (elem_in[g].guard),
            .sticky_in    (elem_in[g].sticky),
            .round_up_out (round_up_out[g])
         );
      end
   endgenerate

   always_comb begin
      cause_acc = 6'h00;
      flag_acc  = 5'h00;
      for (int i = 0; i < NUM_ELEM; i++) begin
         if (elem_valid_in[i]) begin
            cause_acc = cause_acc | cond[i];
         end
         flag_acc = flag_acc | flag_part[i];
      end
   end

   assign done_trap = done_in & ~nontrap_select
      & (|(cause_acc & {1'b1, enable}));
   assign wr_trap = csr_wr_in & ~csr_wdata_in.nontrap_select
      & (|(csr_wdata_in.cause & {1'b1, csr_wdata_in.enable}));

   // rounding selector and mode bit
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         round_select   <= `ROUND_RESET;
         nontrap_select <= `NONTRAP_RESET;
      end else if (csr_wr_in) begin
         round_select   <= csr_wdata_in.round_select;
         nontrap_select <= csr_wdata_in.nontrap_select;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         enable <= `ENABLE_RESET;
      end else if (csr_wr_in) begin
         enable <= csr_wdata_in.enable;
      end
   end

   // outside non-trapping mode, datapath outranks a simultaneous software write of cause
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         cause <= `CAUSE_RESET;
      end else if (done_in && !nontrap_select) begin
         cause <= cause_acc;
      end else if (csr_wr_in) begin
         cause <= csr_wdata_in.cause;
      end
   end

   // no reset: value stays undefined until software writes it
   always_ff @(posedge ref_clk_in) begin
      if (done_in) begin
         flags <= (csr_wr_in ? csr_wdata_in.flags : flags) | flag_acc;
      end else if (csr_wr_in) begin
         flags <= csr_wdata_in.flags;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         trap_out <= 1'b0;
      end else begin
         trap_out <= done_trap | wr_trap;
      end
   end

   assign csr_out = {nontrap_select, cause, enable, flags, round_select};

   property p_flags_hold;
      @(posedge ref_clk_in) disable iff (srst_in)
      (!done_in && !csr_wr_in) |=> $stable(csr_out.flags);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags changed by hardware");

   property p_flags_accum;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && !csr_wr_in) |=> (csr_out.flags == ($past(csr_out.flags) | $past(flag_acc)));
   endproperty
   a_flags_accum: assert property (p_flags_accum) else $error("flags not accumulated");

   property p_trapped_no_flag;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && !csr_wr_in && elem_valid_in == 1 && !nontrap_select
       && (|(cond[0][4:0] & enable))) |=> $stable(csr_out.flags);
   endproperty
   a_trapped_no_flag: assert property (p_trapped_no_flag) else $error("trapping op set flags");

   property p_cause_update;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && !nontrap_select) |=> (csr_out.cause == $past(cause_acc));
   endproperty
   a_cause_update: assert property (p_cause_update) else $error("cause not recorded");

   property p_nontrap;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && nontrap_select && !csr_wr_in) |=> (!trap_out && $stable(csr_out.cause));
   endproperty
   a_nontrap: assert property (p_nontrap) else $error("non-trapping mode trapped");

   property p_write_trap;
      @(posedge ref_clk_in) disable iff (srst_in)
      (csr_wr_in && !csr_wdata_in.nontrap_select
       && (|(csr_wdata_in.cause & {1'b1, csr_wdata_in.enable}))) |=> trap_out;
   endproperty
   a_write_trap: assert property (p_write_trap) else $error("write did not trap");

   property p_qnan;
      @(posedge ref_clk_in) disable iff (srst_in)
      (elem_in[0].invalid && !eff_en[`C_INVALID])
      |=> (default_kind_out[0] == vfp_status_pkg::DEF_QNAN);
   endproperty
   a_qnan: assert property (p_qnan) else $error("no quiet nan default");

   property p_inf;
      @(posedge ref_clk_in) disable iff (srst_in)
      (elem_in[0].div_zero && !elem_in[0].invalid && !eff_en[`C_DIV_ZERO])
      |=> (default_kind_out[0] == vfp_status_pkg::DEF_INF && default_sign_out[0] == $past(elem_in[0].sign));
   endproperty
   a_inf: assert property (p_inf) else $error("no signed infinity default");

   property p_ovf_inexact;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && !nontrap_select && elem_valid_in[0] && elem_in[0].overflow
       && !enable[`C_OVERFLOW]) |=> csr_out.cause[`C_INEXACT];
   endproperty
   a_ovf_inexact: assert property (p_ovf_inexact) else $error("overflow without inexact");

   property p_exact_tiny;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && !nontrap_select && elem_valid_in == 1 && elem_in[0].tiny
       && !elem_in[0].inexact && !elem_in[0].overflow && !enable[`C_UNDERFLOW])
      |=> !csr_out.cause[`C_UNDERFLOW] && !csr_out.cause[`C_INEXACT];
   endproperty
   a_exact_tiny: assert property (p_exact_tiny) else $error("exact tiny raised flags");

   // control fields follow a whole-word write on the next edge
   property p_ctrl_write;
      @(posedge ref_clk_in) disable iff (srst_in)
      csr_wr_in |=> (csr_out.round_select == $past(csr_wdata_in.round_select)
         && csr_out.enable == $past(csr_wdata_in.enable)
         && csr_out.nontrap_select == $past(csr_wdata_in.nontrap_select));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   // no disable here, so the reset values themselves are looked at
   property p_ctrl_reset;
      @(posedge ref_clk_in)
      srst_in |=> (csr_out.round_select == `ROUND_RESET && csr_out.nontrap_select == `NONTRAP_RESET
         && csr_out.enable == `ENABLE_RESET && csr_out.cause == `CAUSE_RESET && !trap_out);
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reset");

   // a clear and a set in one cycle: the set wins
   property p_flags_set_wins;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && csr_wr_in) |=> (csr_out.flags == ($past(csr_wdata_in.flags) | $past(flag_acc)));
   endproperty
   a_flags_set_wins: assert property (p_flags_set_wins) else $error("flag set lost to clear");

   property p_flags_write;
      @(posedge ref_clk_in) disable iff (srst_in)
      (csr_wr_in && !done_in) |=> (csr_out.flags == $past(csr_wdata_in.flags));
   endproperty
   a_flags_write: assert property (p_flags_write) else $error("flag write lost");

   property p_nontrap_flags;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && !csr_wr_in && nontrap_select && elem_valid_in == 1)
      |=> (csr_out.flags == ($past(csr_out.flags) | $past(cond[0][4:0])));
   endproperty
   a_nontrap_flags: assert property (p_nontrap_flags) else $error("non-trapping flags lost");

   // unimplemented traps even with every enable bit clear
   property p_unimpl_trap;
      @(posedge ref_clk_in) disable iff (srst_in)
      (done_in && !nontrap_select && elem_valid_in[0] && elem_in[0].unimpl)
      |=> (trap_out && csr_out.cause[`C_UNIMPL]);
   endproperty
   a_unimpl_trap: assert property (p_unimpl_trap) else $error("unimplemented did not trap");

   property p_no_spurious_trap;
      @(posedge ref_clk_in) disable iff (srst_in)
      (!done_in && !csr_wr_in) |=> !trap_out;
   endproperty
   a_no_spurious_trap: assert property (p_no_spurious_trap) else $error("trap without cause");

   property p_default_rounded;
      @(posedge ref_clk_in) disable iff (srst_in)
      (!elem_in[0].invalid && !elem_in[0].div_zero)
      |=> (default_kind_out[0] == vfp_status_pkg::DEF_ROUNDED);
   endproperty
   a_default_rounded: assert property (p_default_rounded) else $error("rounded result not kept");

   // a fixed toward-zero rounding overrides the selector
   property p_fixed_rm;
      @(posedge ref_clk_in) disable iff (srst_in)
      (elem_in[0].fixed_rm_valid && elem_in[0].fixed_rm == `RM_ZERO && round_select != `RM_ZERO)
      |=> !round_up_out[0];
   endproperty
   a_fixed_rm: assert property (p_fixed_rm) else $error("fixed rounding ignored");

   c_done_trap: cover property (@(posedge ref_clk_in) disable iff (srst_in) done_trap ##1 trap_out);
   c_write_trap: cover property (@(posedge ref_clk_in) disable iff (srst_in) wr_trap);
   c_accum: cover property (@(posedge ref_clk_in) disable iff (srst_in) done_in && flag_acc != 5'h00);
   c_set_clear: cover property (@(posedge ref_clk_in) disable iff (srst_in) done_in && csr_wr_in);
   c_nontrap_done: cover property (@(posedge ref_clk_in) disable iff (srst_in) done_in && nontrap_select);

endmodule : vector_fp_flags_rounding

`default_nettype wire

// ### src/vfp_status_map.svh
/*
 contents: bit positions, widths, reset values, rounding codes and
 condition bit indices of the vector fp control/status word.
 assumes: included by bare name from the package and design files.
*/
`ifndef VFP_STATUS_MAP_SVH
`define VFP_STATUS_MAP_SVH

// Function
// - sticky five-bit flag field at bits 6:2
// - untrapped condition sets only its own flags
// - trapping element adds none of its flags; other elements still do
// - flags never cleared by hardware, reset included
// - rounding selector 1:0, resets zero, overridable
// - selector 0: nearest, ties to even
// - selector 1: round toward zero
// - selector 2: round toward plus infinity
// - selector 3: round toward minus infinity
// - unimplemented bit only in cause field
// - invalid untrapped delivers quiet nan
// - divide by zero untrapped delivers signed infinity
// - untrapped overflow delivers rounded result, sets inexact
// - enabled underflow signals on any tiny result
// - untrapped underflow: inexact only if inexact
// - inexact when rounding changes the value
// - enable field 11:7 gates traps, also writes
// - cause field 17:12 per instruction
// - mode bit 18 selects non-trapping, resets zero

`define CSR_W          19
`define FLAGS_LSB      2
`define ENABLE_LSB     7
`define CAUSE_LSB      12
`define NONTRAP_BIT    18
`define ROUND_RESET    2'h0
`define NONTRAP_RESET  1'h0
`define ENABLE_RESET   5'h00
`define CAUSE_RESET    6'h00
`define RM_NEAREST     2'h0
`define RM_ZERO        2'h1
`define RM_PLUS        2'h2
`define RM_MINUS       2'h3
`define C_INEXACT      0
`define C_UNDERFLOW    1
`define C_OVERFLOW     2
`define C_DIV_ZERO     3
`define C_INVALID      4
`define C_UNIMPL       5
`define NUM_ELEM       4

`endif

// ### src/vfp_status_pkg.sv
/*
 contents: packed carriers for the control/status word and the
 per-element reports of the fp datapath.
 assumes: field layout constants come from the map header.
*/
`include "vfp_status_map.svh"
`default_nettype none

package vfp_status_pkg;

   // bit 18 down to bit 0, same as the architectural word
   typedef struct packed {
      logic       nontrap_select;
      logic [5:0] cause;
      logic [4:0] enable;
      logic [4:0] flags;
      logic [1:0] round_select;
   } csr_type;

   typedef struct packed {
      logic       unimpl;
      logic       invalid;
      logic       div_zero;
      logic       overflow;
      logic       tiny;
      logic       inexact;
      logic       sign;
      logic       lsb;
      logic       guard;
      logic       sticky;
      logic       fixed_rm_valid;
      logic [1:0] fixed_rm;
   } elem_report_type;

   typedef enum logic [1:0] {
      DEF_ROUNDED = 2'b00,
      DEF_QNAN    = 2'b01,
      DEF_INF     = 2'b10
   } default_kind_type;

endpackage : vfp_status_pkg

`default_nettype wire

// ### verification/fp_datapath_model.sv
/*
 contents: stand-in for the vector fp datapath: completion pulses and
 per-element condition and rounding reports.
 assumes: the bench calls send just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module fp_datapath_model #(
   parameter int N = 4
) (
   // reports towards the status logic
   output logic                                    done_out,
   output logic [N-1:0]                            valid_out,
   output vfp_status_pkg::elem_report_type [N-1:0] elem_out
);
   initial begin
      done_out  = 1'b0;
      valid_out = '0;
      elem_out  = '0;
   end

   // reports are levels read every cycle, so fresh bits go out on every call
   task automatic send(input logic d, input logic [N-1:0] v, input logic [13*N-1:0] r);
      done_out  = d;
      valid_out = v;
      elem_out  = r;
   endtask : send
endmodule : fp_datapath_model

`default_nettype wire

// ### verification/tb_top.sv
/*
 contents: self-checking bench with a cycle model of the status logic.
 assumes: package compiled first; datapath model drives the reports.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", name, exp, got); end end

module tb_top;
   localparam int N = 4;
   logic                                     ref_clk_in;
   logic                                     srst_in;
   logic                                     csr_wr_in;
   logic                                     trap_out;
   logic                                     m_trap;
   logic                                     m_fk;
   vfp_status_pkg::csr_type                  csr_wdata_in;
   vfp_status_pkg::csr_type                  csr_out;
   vfp_status_pkg::csr_type                  m_csr;
   vfp_status_pkg::csr_type                  w;
   wire logic                                done_in;
   wire logic [N-1:0]                        elem_valid_in;
   wire vfp_status_pkg::elem_report_type [N-1:0] elem_in;
   vfp_status_pkg::default_kind_type [N-1:0] default_kind_out;
   logic [N-1:0]                             round_up_out;
   logic [N-1:0]                             default_sign_out;
   logic [N-1:0]                             m_ru;
   logic [N-1:0]                             m_ds;
   logic [2*N-1:0]                           m_dk;
   logic [31:0]                              q;
   integer                                   mismatches;
   integer                                   check_count;
   integer                                   seed;
   integer                                   cycles;
   integer                                   i;

   vector_fp_flags_rounding #(.NUM_ELEM(N)) vector_fp_flags_rounding_i (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .csr_wr_in(csr_wr_in),
      .csr_wdata_in(csr_wdata_in), .csr_out(csr_out), .done_in(done_in),
      .elem_valid_in(elem_valid_in), .elem_in(elem_in), .trap_out(trap_out),
      .round_up_out(round_up_out), .default_kind_out(default_kind_out),
      .default_sign_out(default_sign_out));

   fp_datapath_model #(.N(N)) fp_datapath_model_i (
      .done_out(done_in), .valid_out(elem_valid_in), .elem_out(elem_in));

   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // whole run is well under 1000 cycles
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         print_verdict();
      end
   end

   // next state of the model from the inputs now on the ports
   task automatic predict();
      logic [4:0] en, c5, fl;
      logic [5:0] ca;
      logic       nt;
      logic [1:0] md;
      vfp_status_pkg::elem_report_type e;
      en = m_csr.enable;
      nt = m_csr.nontrap_select;
      ca = '0;
      fl = '0;
      for (int k = 0; k < N; k++) begin
         e  = elem_in[k];
         md = e.fixed_rm_valid ? e.fixed_rm : m_csr.round_select;
         case (md)
            2'h0: m_ru[k] = e.guard & (e.sticky | e.lsb);
            2'h1: m_ru[k] = 1'b0;
            2'h2: m_ru[k] = !e.sign & (e.guard | e.sticky);
            default: m_ru[k] = e.sign & (e.guard | e.sticky);
         endcase
         m_ds[k] = e.sign;
         m_dk[2*k+:2] = (e.invalid & (nt | !en[4])) ? 2'h1 : (e.div_zero & (nt | !en[3])) ? 2'h2 : 2'h0;
         c5 = {e.invalid, e.div_zero, e.overflow, e.tiny & (en[1] | e.inexact), e.inexact | (e.overflow & !en[2])};
         if (elem_valid_in[k]) begin
            ca |= {e.unimpl, c5};
            if (nt | !(e.unimpl | (|(c5 & en)))) fl |= c5;
         end
      end
      m_trap = 1'b0;
      if (srst_in) begin
         m_csr = {1'h0, 6'h00, 5'h00, m_csr.flags, 2'h0};
         m_ru  = '0;
         m_dk  = '0;
         m_ds  = '0;
      end else begin
         if (csr_wr_in) begin
            m_csr  = csr_wdata_in;
            m_fk   = 1'b1;
            m_trap = !csr_wdata_in.nontrap_select & (|(csr_wdata_in.cause & {1'b1, csr_wdata_in.enable}));
         end
         // a completion in the same cycle still sets flags and, outside non-trapping mode, owns the cause field
         if (done_in) begin
            m_csr.flags |= fl;
            if (!nt) begin
               m_csr.cause = ca;
               m_trap      = m_trap | (|(ca & {1'b1, en}));
            end
         end
      end
   endtask : predict

   task automatic cycle();
      // port nets of the datapath model settle before the model reads them
      #1;
      predict();
      @(posedge ref_clk_in);
      #1;
      if (m_fk) `CHK("csr word", m_csr, csr_out)
      else `CHK("csr control", {m_csr[18:7], m_csr[1:0]}, {csr_out[18:7], csr_out[1:0]})
      `CHK("trap", m_trap, trap_out)
      `CHK("round up", m_ru, round_up_out)
      `CHK("default kind", m_dk, default_kind_out)
      `CHK("default sign", m_ds, default_sign_out)
   endtask : cycle

   task automatic step(input logic rs, input logic wr, input vfp_status_pkg::csr_type wd,
                       input logic d, input logic [N-1:0] v);
      logic [63:0] r;
      r            = {$random(seed), $random(seed)};
      srst_in      = rs;
      csr_wr_in    = wr;
      csr_wdata_in = wd;
      fp_datapath_model_i.send(d, v, r[13*N-1:0]);
      cycle();
   endtask : step

   initial begin
      mismatches   = 0;
      check_count  = 0;
      cycles       = 0;
      seed         = 32'h5827;
      m_fk         = 1'b0;
      srst_in      = 1'b1;
      csr_wr_in    = 1'b0;
      csr_wdata_in = '0;
      @(posedge ref_clk_in);
      #1;
      for (i = 0; i < 12; i++) step(1'b1, 1'b0, '0, 1'b0, '0);
      $display("test reset done");
      // selector codes in turn, reports streaming with no completion
      for (i = 0; i < 80; i++) begin
         w              = '0;
         w.round_select = i / 20;
         step(1'b0, (i % 20) == 0, w, 1'b0, '0);
      end
      $display("test rounding done");
      // whole-word writes with random cause, enable and mode
      for (i = 0; i < 24; i++) begin
         q = $random(seed);
         step(1'b0, 1'b1, q[18:0], 1'b0, '0);
      end
      $display("test write trap done");
      // completions mixed with writes, some in one cycle; a reset in mid-run keeps the flags
      for (i = 0; i < 300; i++) begin
         q = $random(seed);
         w = q[31:13];
         if (q[3:2] != 2'h0) w.flags = 5'h00;
         if (i == 150 || i == 151) step(1'b1, 1'b0, w, 1'b0, q[7:4]);
         else step(1'b0, q[1:0] == 2'h0 || q[1:0] == 2'h3, w, q[1:0] != 2'h0, q[7:4]);
      end
      $display("test completion done");
      print_verdict();
   end
endmodule : tb_top

`default_nettype wire
